// >>> bcea_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Pair-field clock runs if any bit zero
// - Pair-field clock stops when both bits set
// - Single bits 8-13 stop outputs 4-9 low
// - Clock bits 15:14 read zero, writes ignored
// - Bit 16: address parity error raised error
// - Bit 17: posted write data parity error
// - Bit 18: posted write never delivered
// - Bit 19: target abort on posted write
// - Bit 20: master abort on posted write
// - Bit 21: delayed write never delivered
// - Bit 22: delayed read got no data
// - Bit 23: delayed transaction master timeout
// - Option bit 0 always reads zero
// - Primary read alias, reset one
// - Primary write-invalidate alias, reset zero
// - Secondary read alias, reset one
// - Secondary write-invalidate alias, reset zero
// - Primary line/multiple interchange, reset one
// - Status sets only when enabled, unmasked
module bcea_regs #(
  parameter int NUM_CLKS = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_ack,
  // Error events from the bridge core
  input wire logic [7:0] err_event,
  input wire logic [7:0] err_report_disable,
  input wire logic serr_enable,
  // Primary system error pin, open drain
  output logic primary_system_error_out_o,
  output logic primary_system_error_out_oe_n,
  // Secondary clock pins
  output logic [NUM_CLKS-1:0] secondary_clock_outputs,
  // Primary retry matching
  input wire logic pri_retry_valid,
  input wire logic [3:0] pri_queued_cmd,
  input wire logic [3:0] pri_retry_cmd,
  output logic pri_retry_match,
  // Secondary retry matching
  input wire logic sec_retry_valid,
  input wire logic [3:0] sec_queued_cmd,
  input wire logic [3:0] sec_retry_cmd,
  output logic sec_retry_match
);

  // ==========================================================
  // Register storage
  logic [13:0] clk_ctl_r;       // Gating fields, reserved bits not stored
  logic [13:0] clk_ctl_nxt;
  logic [7:0] stat_r;           // Sticky error causes
  logic [7:0] stat_nxt;
  logic [5:1] opt_r;            // Alias enables
  logic [5:1] opt_nxt;
  logic [31:0] rdata_nxt;
  logic phase_r;                // Divided clock source
  logic [NUM_CLKS-1:0] sclk_r;  // Registered clock outputs
  logic [NUM_CLKS-1:0] clk_run; // Per-output enable
  logic [7:0] stat_set;         // Qualified events this cycle
  logic [7:0] stat_clr;         // Write-one-to-clear mask
  logic serr_oe_n_r;            // Pin drive, low while pulling
  logic pri_match_r;
  logic sec_match_r;
  logic hit_clk;                // Access targets 68h
  logic hit_opt;                // Access targets 74h

  // ==========================================================
  // Matchers for the two ports
  bcea_match_if pri_if ();
  bcea_match_if sec_if ();

  // Primary port uses all three alias controls
  assign pri_if.queued_cmd = pri_queued_cmd;
  assign pri_if.retry_cmd = pri_retry_cmd;
  assign pri_if.rd_alias = opt_r[bcea_pkg::OPT_PRI_RD];
  assign pri_if.wr_alias = opt_r[bcea_pkg::OPT_PRI_WR];
  assign pri_if.lm_alias = opt_r[bcea_pkg::OPT_PRI_LM];

  // Secondary line/multiple swap lives in a bit not kept here
  assign sec_if.queued_cmd = sec_queued_cmd;
  assign sec_if.retry_cmd = sec_retry_cmd;
  assign sec_if.rd_alias = opt_r[bcea_pkg::OPT_SEC_RD];
  assign sec_if.wr_alias = opt_r[bcea_pkg::OPT_SEC_WR];
  assign sec_if.lm_alias = 1'b0;

  bcea_retry_match u_pri_match (
    .m(pri_if.matcher)
  );

  bcea_retry_match u_sec_match (
    .m(sec_if.matcher)
  );

  // ==========================================================
  // Address decode, dword granularity
  assign hit_clk = (cfg_addr[7:2] == bcea_pkg::OFF_CLK_STAT[7:2]);
  assign hit_opt = (cfg_addr[7:2] == bcea_pkg::OFF_PORT_OPT[7:2]);

  // ==========================================================
  // Clock gating register write, byte lanes 0 and 1
  always_comb begin
    clk_ctl_nxt = clk_ctl_r;
    if (cfg_wr && hit_clk) begin
      if (cfg_be[0]) begin
        clk_ctl_nxt[7:0] = cfg_wdata[7:0];
      end
      // Bits 15:14 are dropped on write
      if (cfg_be[1]) begin
        clk_ctl_nxt[13:8] = cfg_wdata[13:8];
      end
    end
  end

  // Hold gating fields
  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_ctl_r <= bcea_pkg::CLK_CTL_RST;
    end else begin
      clk_ctl_r <= clk_ctl_nxt;
    end
  end

  // ==========================================================
  // Per-output run decision
  always_comb begin
    clk_run = '0;
    for (int i = 0; i < bcea_pkg::NUM_PAIR_CLKS; i++) begin
      // Stop only when both bits of the pair are one
      clk_run[i] = ~&clk_ctl_r[2*i +: 2];
    end
    for (int i = bcea_pkg::NUM_PAIR_CLKS; i < NUM_CLKS; i++) begin
      // Single bit: zero runs, one stops
      clk_run[i] = ~clk_ctl_r[bcea_pkg::SINGLE_CLK_LSB + i - bcea_pkg::NUM_PAIR_CLKS];
    end
  end

  // Divide by two so every output is a clean registered square wave
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  // Stopped outputs park low; enabling restarts in phase with the rest
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CLKS; i++) begin
        sclk_r[i] <= clk_run[i] ? ~phase_r : 1'b0;
      end
    end
  end

  // ==========================================================
  // Error cause capture
  always_comb begin
    // Only unmasked events count, and only with error reporting on
    stat_set = err_event & ~err_report_disable & {8{serr_enable}};
    stat_clr = '0;
    if (cfg_wr && hit_clk && cfg_be[2]) begin
      stat_clr = cfg_wdata[bcea_pkg::STAT_LSB +: 8];
    end
    // A new event wins over a clear in the same cycle
    stat_nxt = (stat_r & ~stat_clr) | stat_set;
  end

  // Sticky status bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_r <= bcea_pkg::STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // Pull the error pin low for one cycle per qualified event
  always_ff @(posedge mclk) begin
    if (rst) begin
      serr_oe_n_r <= 1'b1;
    end else begin
      serr_oe_n_r <= ~|stat_set;
    end
  end

  // ==========================================================
  // Port option register, byte lane 0 only
  always_comb begin
    opt_nxt = opt_r;
    if (cfg_wr && hit_opt && cfg_be[0]) begin
      // Bit 0 is not stored
      opt_nxt = cfg_wdata[5:1];
    end
  end

  // Alias enables
  always_ff @(posedge mclk) begin
    if (rst) begin
      opt_r <= bcea_pkg::OPT_RST;
    end else begin
      opt_r <= opt_nxt;
    end
  end

  // ==========================================================
  // Match results, registered on a valid retry
  always_ff @(posedge mclk) begin
    if (rst) begin
      pri_match_r <= 1'b0;
      sec_match_r <= 1'b0;
    end else begin
      pri_match_r <= pri_retry_valid && pri_if.match;
      sec_match_r <= sec_retry_valid && sec_if.match;
    end
  end

  // ==========================================================
  // Read data mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = '0;
    if (hit_clk) begin
      // Bits 15:14 and 31:24 read zero
      rdata_nxt[13:0] = clk_ctl_r;
      rdata_nxt[bcea_pkg::STAT_LSB +: 8] = stat_r;
    end else if (hit_opt) begin
      rdata_nxt[5:1] = opt_r;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_rdata <= '0;
      cfg_rd_ack <= 1'b0;
    end else begin
      cfg_rd_ack <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= rdata_nxt;
      end
    end
  end

  // ==========================================================
  // Output hookup, all from flip-flops
  assign secondary_clock_outputs = sclk_r;
  assign primary_system_error_out_oe_n = serr_oe_n_r;
  assign pri_retry_match = pri_match_r;
  assign sec_retry_match = sec_match_r;

  // Pin level is always low when driven
  always_ff @(posedge mclk) begin
    primary_system_error_out_o <= 1'b0;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_pair_run;
    (!clk_ctl_r[0] || !clk_ctl_r[1]) && $stable(clk_ctl_r) |=> sclk_r[0] != $past(sclk_r[0]);
  endproperty
  a_pair_run: assert property (p_pair_run) else $error("pair clock not toggling");

  property p_pair_stop;
    (&clk_ctl_r[7:6]) |=> !sclk_r[3];
  endproperty
  a_pair_stop: assert property (p_pair_stop) else $error("pair clock not stopped");

  property p_single_low;
    clk_ctl_r[13] |=> !secondary_clock_outputs[9];
  endproperty
  a_single_low: assert property (p_single_low) else $error("single clock not low");

  // Three clear cycles: both compared output samples were launched while running
  property p_single_run;
    !clk_ctl_r[8] [*3] |-> secondary_clock_outputs[4] != $past(secondary_clock_outputs[4]);
  endproperty
  a_single_run: assert property (p_single_run) else $error("single clock not toggling");

  property p_clk_rsv;
    cfg_rd && hit_clk |=> cfg_rd_ack && cfg_rdata[15:14] == 2'h0 && cfg_rdata[31:24] == 8'h00;
  endproperty
  a_clk_rsv: assert property (p_clk_rsv) else $error("reserved clock bits nonzero");

  property p_stat_set;
    |stat_set |=> ((stat_r & $past(stat_set)) == $past(stat_set)) && !primary_system_error_out_oe_n;
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("event not recorded");

  property p_w1c;
    cfg_wr && hit_clk && cfg_be[2] && cfg_wdata[16] && !stat_set[0] |=> !stat_r[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared");

  property p_sticky;
    stat_r[7] && !(cfg_wr && hit_clk && cfg_be[2] && cfg_wdata[23]) |=> stat_r[7];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");

  property p_opt_rsv;
    cfg_rd && hit_opt |=> !cfg_rdata[0];
  endproperty
  a_opt_rsv: assert property (p_opt_rsv) else $error("option bit 0 nonzero");

  property p_pri_rd;
    pri_retry_valid && opt_r[1] && pri_queued_cmd == 4'h6 && pri_retry_cmd == 4'hE |=> pri_retry_match;
  endproperty
  a_pri_rd: assert property (p_pri_rd) else $error("primary read alias missed");

  property p_pri_wr_exact;
    pri_retry_valid && !opt_r[2] && pri_queued_cmd == 4'h7 && pri_retry_cmd == 4'hF |=> !pri_retry_match;
  endproperty
  a_pri_wr_exact: assert property (p_pri_wr_exact) else $error("primary write not exact");

  property p_sec_rd;
    sec_retry_valid && opt_r[3] && sec_queued_cmd == 4'h6 && sec_retry_cmd == 4'hC |=> sec_retry_match;
  endproperty
  a_sec_rd: assert property (p_sec_rd) else $error("secondary read alias missed");

  property p_sec_wr;
    sec_retry_valid && opt_r[4] && sec_queued_cmd == 4'h7 && sec_retry_cmd == 4'hF |=> sec_retry_match;
  endproperty
  a_sec_wr: assert property (p_sec_wr) else $error("secondary write alias missed");

  property p_pri_lm;
    pri_retry_valid && pri_queued_cmd == 4'hE && pri_retry_cmd == 4'hC |=> pri_retry_match == $past(opt_r[5]);
  endproperty
  a_pri_lm: assert property (p_pri_lm) else $error("line/multiple alias wrong");

  property p_gate;
    !serr_enable |=> (stat_r & ~$past(stat_r)) == 8'h00;
  endproperty
  a_gate: assert property (p_gate) else $error("status set while disabled");

endmodule

// >>> bcea_pkg.sv
// ==========================================================
// Shared constants for the clock, error and alias registers
package bcea_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CLK_STAT = 8'h68;  // Clock gating + error cause
  localparam logic [7:0] OFF_PORT_OPT = 8'h74;  // Retry match options
  // ==========================================================
  // Clock gating field layout
  localparam int NUM_PAIR_CLKS = 4;             // Outputs with a 2-bit field
  localparam int SINGLE_CLK_LSB = 8;            // First single-bit field
  localparam int CLK_RSV_LSB = 14;              // Reserved bits 15:14
  localparam logic [13:0] CLK_CTL_RST = 14'h0000;  // All outputs running
  // ==========================================================
  // Error cause status field
  localparam int STAT_LSB = 16;                 // Status byte lane 2
  localparam logic [7:0] STAT_RST = 8'h00;
  // ==========================================================
  // Port option bits
  localparam int OPT_PRI_RD = 1;                // Primary read alias
  localparam int OPT_PRI_WR = 2;                // Primary write alias
  localparam int OPT_SEC_RD = 3;                // Secondary read alias
  localparam int OPT_SEC_WR = 4;                // Secondary write alias
  localparam int OPT_PRI_LM = 5;                // Primary line/multiple alias
  localparam logic [5:1] OPT_RST = 5'h15;       // Bits 1,3,5 set
  // ==========================================================
  // Bus command codes used by retry matching
  typedef enum logic [3:0] {
    plain_memory_read_cmd = 4'h6,
    plain_memory_write_cmd = 4'h7,
    read_multiple_cmd = 4'hC,
    read_line_cmd = 4'hE,
    write_invalidate_cmd = 4'hF
  } bcea_cmd_t;
endpackage

// >>> bcea_match_if.sv
`timescale 1ns/1ps
// ==========================================================
// Carries one port's retry comparison into the matcher
interface bcea_match_if;
  logic [3:0] queued_cmd;   // Command held in the request queue
  logic [3:0] retry_cmd;    // Command of the retried cycle
  logic rd_alias;           // Read line/multiple may match plain read
  logic wr_alias;           // Write-invalidate may match plain write
  logic lm_alias;           // Read line and multiple interchange
  logic match;              // Comparison result
  modport owner (output queued_cmd, retry_cmd, rd_alias, wr_alias, lm_alias, input match);
  modport matcher (input queued_cmd, retry_cmd, rd_alias, wr_alias, lm_alias, output match);
endinterface

// >>> bcea_retry_match.sv
`timescale 1ns/1ps
// ==========================================================
// Retry command matcher, one per bus port
module bcea_retry_match (
  bcea_match_if.matcher m
);
  logic exact;   // Same command
  logic rd_hit;  // Aliased read
  logic wr_hit;  // Aliased write
  logic lm_hit;  // Line/multiple swap

  // ==========================================================
  // Compare the retried command against the queued one
  always_comb begin
    exact = (m.retry_cmd == m.queued_cmd);
    // Line or multiple retried against a queued plain read
    rd_hit = m.rd_alias && (m.queued_cmd == bcea_pkg::plain_memory_read_cmd) &&
             ((m.retry_cmd == bcea_pkg::read_line_cmd) ||
              (m.retry_cmd == bcea_pkg::read_multiple_cmd));
    // Write-invalidate retried against a queued plain write
    wr_hit = m.wr_alias && (m.queued_cmd == bcea_pkg::plain_memory_write_cmd) &&
             (m.retry_cmd == bcea_pkg::write_invalidate_cmd);
    // Line and multiple treated as one another
    lm_hit = m.lm_alias &&
             (((m.queued_cmd == bcea_pkg::read_line_cmd) &&
               (m.retry_cmd == bcea_pkg::read_multiple_cmd)) ||
              ((m.queued_cmd == bcea_pkg::read_multiple_cmd) &&
               (m.retry_cmd == bcea_pkg::read_line_cmd)));
    m.match = exact || rd_hit || wr_hit || lm_hit;
  end
endmodule

// >>> bcea_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side: issues configuration reads and writes
module bcea_host_model (
  // Clock
  input wire logic mclk,
  // Configuration access
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rd_ack
);
  // Idle bus from time zero
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end
  // One write; the strobe stands for exactly one edge
  task automatic do_write(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data);
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_addr <= addr;
    cfg_be <= be;
    cfg_wdata <= data;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    // Released lines show inverted values so stale data never looks valid
    cfg_addr <= ~addr;
    cfg_be <= ~be;
    cfg_wdata <= ~data;
  endtask
  // One read; data taken in the cycle the answer stands
  task automatic do_read(input logic [7:0] addr, output logic [31:0] data);
    int n;
    @(posedge mclk);
    cfg_rd <= 1'b1;
    cfg_addr <= addr;
    cfg_be <= 4'hF;
    @(posedge mclk);
    cfg_rd <= 1'b0;
    cfg_addr <= ~addr;
    n = 0;
    #1;
    // Bounded wait, so a missing answer cannot hang the run
    while (cfg_rd_ack !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    data = (cfg_rd_ack === 1'b1) ? cfg_rdata : {32{1'bx}};
  endtask
endmodule

// >>> bcea_regs_bench.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the clock, error and alias registers
module bcea_regs_bench;
  logic mclk;
  logic rst;
  logic cfg_wr, cfg_rd, cfg_rd_ack;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  logic [7:0] err_event, err_report_disable;
  logic serr_enable, pin_o, pin_oe_n;
  logic [9:0] clk_out, s1, s2;
  logic pri_retry_valid, sec_retry_valid, pri_retry_match, sec_retry_match;
  logic [3:0] q_cmd, r_cmd;  // Same commands offered to both ports
  int failures, tests_run, cycles, n;

  // ==========================================================
  // Clock, host model and design
  always #25 mclk = ~mclk;
  bcea_host_model u_host (.mclk(mclk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_ack(cfg_rd_ack));
  bcea_regs #(.NUM_CLKS(10)) u_dut (.mclk(mclk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rd_ack(cfg_rd_ack), .err_event(err_event), .err_report_disable(err_report_disable),
    .serr_enable(serr_enable), .primary_system_error_out_o(pin_o),
    .primary_system_error_out_oe_n(pin_oe_n), .secondary_clock_outputs(clk_out),
    .pri_retry_valid(pri_retry_valid), .pri_queued_cmd(q_cmd), .pri_retry_cmd(r_cmd),
    .pri_retry_match(pri_retry_match), .sec_retry_valid(sec_retry_valid), .sec_queued_cmd(q_cmd),
    .sec_retry_cmd(r_cmd), .sec_retry_match(sec_retry_match));

  // ==========================================================
  // Checking helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp);
    u_host.do_read(addr, rd);
    check(rd, exp, "register read");
  endtask
  // Running outputs differ on two neighbouring cycles, stopped ones sit low
  task automatic clk_check(input logic [9:0] run);
    @(posedge mclk);
    #1 s1 = clk_out;
    @(posedge mclk);
    #1 s2 = clk_out;
    check({22'h0, s1 ^ s2}, {22'h0, run}, "clock toggle");
    check({22'h0, (s1 | s2) & ~run}, 32'h0, "stopped clock level");
  endtask
  // One event pulse; the pin pulls low for one cycle only when qualified
  task automatic event_check(input int bit_n, input logic [7:0] dis, input logic en, input logic hit);
    @(posedge mclk);
    err_event <= 8'h01 << bit_n;
    err_report_disable <= dis;
    serr_enable <= en;
    @(posedge mclk);
    err_event <= 8'h00;
    #1 check({30'h0, pin_o, pin_oe_n}, {31'h0, !hit}, "error pin");
    @(posedge mclk);
    #1 check({31'h0, pin_oe_n}, 32'h1, "error pin release");
  endtask
  // Retry compare on one port; the idle port must stay quiet
  task automatic match(input logic sec, input logic [3:0] q, input logic [3:0] r, input logic exp);
    @(posedge mclk);
    pri_retry_valid <= !sec;
    sec_retry_valid <= sec;
    q_cmd <= q;
    r_cmd <= r;
    @(posedge mclk);
    pri_retry_valid <= 1'b0;
    sec_retry_valid <= 1'b0;
    #1 check({30'h0, pri_retry_match, sec_retry_match}, {30'h0, !sec && exp, sec && exp}, "retry match");
  endtask

  // ==========================================================
  // Verdict and hang guard
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    // Whole sequence needs well under a thousand cycles
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    err_event = 8'h00;
    err_report_disable = 8'h00;
    serr_enable = 1'b0;
    pri_retry_valid = 1'b0;
    sec_retry_valid = 1'b0;
    q_cmd = 4'h0;
    r_cmd = 4'h0;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_check(bcea_pkg::OFF_CLK_STAT, 32'h0000_0000);
    rd_check(bcea_pkg::OFF_PORT_OPT, 32'h0000_002A);
    rd_check(8'h70, 32'h0000_0000);
    clk_check(10'h3FF);
    // Pair fields 11,01,10,11; single bits 1,0,1,0,1,0; reserved bits written one
    u_host.do_write(bcea_pkg::OFF_CLK_STAT, 4'h3, 32'h0000_D5E7);
    rd_check(bcea_pkg::OFF_CLK_STAT, 32'h0000_15E7);
    clk_check(10'h2A6);
    // Each cause: set, survive a zero write, clear by a one write
    for (n = 0; n < 8; n++) begin
      event_check(n, 8'h00, 1'b1, 1'b1);
      rd_check(bcea_pkg::OFF_CLK_STAT, 32'h0000_15E7 | (32'h1 << (16 + n)));
      u_host.do_write(bcea_pkg::OFF_CLK_STAT, 4'h4, 32'h0000_0000);
      rd_check(bcea_pkg::OFF_CLK_STAT, 32'h0000_15E7 | (32'h1 << (16 + n)));
      u_host.do_write(bcea_pkg::OFF_CLK_STAT, 4'h4, 32'h1 << (16 + n));
      rd_check(bcea_pkg::OFF_CLK_STAT, 32'h0000_15E7);
    end
    event_check(3, 8'h08, 1'b1, 1'b0);
    event_check(5, 8'h00, 1'b0, 1'b0);
    rd_check(bcea_pkg::OFF_CLK_STAT, 32'h0000_15E7);
    // Commands: 6 read, 7 write, C multiple, E line, F write-invalidate
    match(1'b0, 4'h6, 4'hE, 1'b1);
    match(1'b0, 4'h6, 4'hC, 1'b1);
    match(1'b0, 4'h7, 4'hF, 1'b0);
    match(1'b1, 4'h6, 4'hC, 1'b1);
    match(1'b1, 4'h7, 4'hF, 1'b0);
    match(1'b0, 4'hC, 4'hE, 1'b1);
    match(1'b1, 4'hC, 4'hE, 1'b0);
    match(1'b0, 4'h7, 4'h6, 1'b0);
    // Flip every option; bit 0 and bit 6 written but not kept
    u_host.do_write(bcea_pkg::OFF_PORT_OPT, 4'h1, 32'h0000_0055);
    rd_check(bcea_pkg::OFF_PORT_OPT, 32'h0000_0014);
    match(1'b0, 4'h6, 4'hE, 1'b0);
    match(1'b0, 4'h7, 4'hF, 1'b1);
    match(1'b1, 4'h6, 4'hE, 1'b0);
    match(1'b1, 4'h7, 4'hF, 1'b1);
    match(1'b0, 4'hE, 4'hC, 1'b0);
    match(1'b0, 4'h6, 4'h6, 1'b1);
    print_verdict();
  end
endmodule
